// ### inc/stc_pkg.sv
// constants and types of the supply track and sequence controller
package stc_pkg;
   // clock and timing
   localparam longint unsigned CLK_HZ        = 64'd40_000_000;
   localparam longint unsigned GOOD_DELAY_US = 64'd200;
   localparam longint unsigned SEQ_DELAY_US  = 64'd200;
   localparam longint unsigned FAULT_TIME_US = 64'd21_910;
   localparam longint unsigned RETRY_TIME_MS = 64'd350;
   localparam int              TW            = 24;
   // least times, rounded up to whole cycles
   localparam logic [TW-1:0] GOOD_DELAY_CYC =
      TW'((GOOD_DELAY_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
   localparam logic [TW-1:0] SEQ_DELAY_CYC  =
      TW'((SEQ_DELAY_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
   localparam logic [TW-1:0] FAULT_TIME_CYC =
      TW'((FAULT_TIME_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
   localparam logic [TW-1:0] RETRY_TIME_CYC =
      TW'((RETRY_TIME_MS * CLK_HZ + 64'd999) / 64'd1_000);

   // register byte addresses
   localparam logic [7:0] ADDR_STATUS     = 8'h00;
   localparam logic [7:0] ADDR_FAULT_TIME = 8'h04;
   localparam logic [7:0] ADDR_RETRY_TIME = 8'h08;
   localparam logic [7:0] ADDR_GOOD_TIME  = 8'h0C;
   localparam logic [7:0] ADDR_SEQ_TIME   = 8'h10;

   // status field positions
   localparam int STS_STATE_POS  = 0;
   localparam int STS_CH_POS     = 8;
   localparam int STS_DONE_POS   = 12;
   localparam int STS_ACTIVE_POS = 16;
   localparam int STS_PG_POS     = 20;
   localparam int STS_FAULTN_POS = 21;
   localparam int STS_TRACK_POS  = 22;
   localparam int STS_RETRY_POS  = 23;

   // pins and reset values
   localparam int         PIN_W    = 26;
   localparam logic [2:0] PD_ALL   = 3'h7;
   localparam logic [2:0] CH_NONE  = 3'h0;

   typedef enum logic [6:0] {
      ST_OFF   = 7'h01,
      ST_DLY   = 7'h02,
      ST_UP    = 7'h04,
      ST_GOOD  = 7'h08,
      ST_ON    = 7'h10,
      ST_DOWN  = 7'h20,
      ST_FAULT = 7'h40
   } stc_state_t;
endpackage

// ### inc/stc_tmr_if.sv
// timer request and answer between controller and timer
`timescale 1ns/1ps
`default_nettype none
interface stc_tmr_if;
   import stc_pkg::*;
   logic          start;
   logic [TW-1:0] load;
   logic          run;
   logic          done;
   modport ctrl (output start, output load, output run, input done);
   modport tmr  (input start, input load, input run, output done);
endinterface
`default_nettype wire

// ### design/stc_timer.sv
// down-counting period timer
`timescale 1ns/1ps
`default_nettype none
module stc_timer (
   // clock and reset
   input  wire logic clock_i,
   input  wire logic reset_n_i,
   // request and answer
   stc_tmr_if.tmr    tmr
);
   import stc_pkg::*;

   logic [TW-1:0] count_q;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i)
         count_q <= '0;
      else if (tmr.run && tmr.start)
         count_q <= tmr.load;
      else if (tmr.run && count_q != '0)
         count_q <= count_q - 1'b1;
   end

   // a zero load expires at once
   assign tmr.done = (count_q == '0);
endmodule
`default_nettype wire

// ### design/stc_ctrl.sv
// three-channel supply tracking and sequencing controller
`timescale 1ns/1ps
`default_nettype none
module stc_ctrl #(
   parameter logic [stc_pkg::TW-1:0] GOOD_CYC_P  = stc_pkg::GOOD_DELAY_CYC,
   parameter logic [stc_pkg::TW-1:0] SEQ_CYC_P   = stc_pkg::SEQ_DELAY_CYC,
   parameter logic [stc_pkg::TW-1:0] FAULT_CYC_P = stc_pkg::FAULT_TIME_CYC,
   parameter logic [stc_pkg::TW-1:0] RETRY_CYC_P = stc_pkg::RETRY_TIME_CYC
) (
   // clock, reset, enable
   input  wire logic        clock_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // comparator and strap pins
   input  wire logic        supply_ok_i,
   input  wire logic        enable_i,
   input  wire logic        margin_n_i,
   input  wire logic        track_or_sequence_pick_i,
   input  wire logic        latch_or_retry_pick_i,
   input  wire logic [2:0]  set_ok_i,
   input  wire logic [2:0]  in_grounded_i,
   input  wire logic [2:0]  out_good_i,
   input  wire logic [2:0]  out_low_i,
   input  wire logic [2:0]  out_below_in_i,
   input  wire logic [2:0]  out_slow_i,
   input  wire logic [2:0]  track_err_i,
   // rail drive and flags
   output logic      [2:0]  gate_ramp_o,
   output logic      [2:0]  gate_full_o,
   output logic      [2:0]  pulldown_o,
   output logic             ramp_up_o,
   output logic             ramp_down_o,
   output logic             ramp_hold_o,
   output logic             power_good_flag_o,
   output logic             fault_n_o
);
   import stc_pkg::*;

   function automatic logic [1:0] first_ch(input logic [2:0] m);
      return m[0] ? 2'h0 : (m[1] ? 2'h1 : 2'h2);
   endfunction

   function automatic logic [2:0] chan_bit(input logic [1:0] c);
      return 3'(3'h1 << c);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [PIN_W-1:0] sync1_q;
   logic [PIN_W-1:0] sync2_q;
   logic             supply_ok_s;
   logic             enable_s;
   logic             margin_n_s;
   logic             track_or_sequence_pick_s;
   logic             latch_or_retry_pick_s;
   logic [2:0]       set_ok_s;
   logic [2:0]       in_grounded_s;
   logic [2:0]       out_good_s;
   logic [2:0]       out_low_s;
   logic [2:0]       out_below_in_s;
   logic [2:0]       out_slow_s;
   logic [2:0]       track_err_s;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (ce_i) begin
         sync1_q <= {supply_ok_i, enable_i, margin_n_i, track_or_sequence_pick_i,
                     latch_or_retry_pick_i, set_ok_i, in_grounded_i, out_good_i,
                     out_low_i, out_below_in_i, out_slow_i, track_err_i};
         sync2_q <= sync1_q;
      end
   end

   assign {supply_ok_s, enable_s, margin_n_s, track_or_sequence_pick_s,
           latch_or_retry_pick_s, set_ok_s, in_grounded_s, out_good_s,
           out_low_s, out_below_in_s, out_slow_s, track_err_s} = sync2_q;

   ////////////////////////////////////////////////////////////////////////////
   // state and decode

   stc_state_t    st_q;
   stc_state_t    st_d;
   logic [1:0]    ch_q;
   logic [1:0]    ch_d;
   logic [2:0]    done_q;
   logic [2:0]    done_d;
   logic [TW-1:0] fault_time_q;
   logic [TW-1:0] retry_time_q;
   logic [TW-1:0] good_time_q;
   logic [TW-1:0] seq_time_q;
   logic          pg_q;
   logic          fault_n_q;
   logic          ramp_hold_q;
   logic          ramp_down_q;
   logic [2:0]    gate_ramp_q;
   logic [2:0]    gate_full_q;
   logic [2:0]    pulldown_q;

   stc_tmr_if phase_tmr ();
   stc_tmr_if fault_tmr ();

   wire [2:0] active_w   = ~(in_grounded_s & set_ok_s);
   wire       track_w    = ~track_or_sequence_pick_s;
   wire       retry_w    = latch_or_retry_pick_s;
   wire       mon_w      = margin_n_s;
   wire       start_ok_w = supply_ok_s & enable_s & (&set_ok_s) & (|active_w);
   wire [2:0] ch_bit_w   = chan_bit(ch_q);
   wire [2:0] left_w     = active_w & ~done_q & ~ch_bit_w;
   wire       all_good_w = &(out_good_s | ~active_w);
   wire       all_low_w  = &(out_low_s | ~active_w);
   wire       up_done_w  = track_w ? all_good_w : out_good_s[ch_q];
   wire       trk_bad_w  = mon_w & (|(track_err_s & active_w));
   wire       below_w    = mon_w & (|(out_below_in_s & done_q));
   // power-up must finish inside the fault period
   wire       up_fault_w = (track_w & trk_bad_w) | (mon_w & fault_tmr.done);
   wire       slow_w     = |(out_slow_s & active_w);

   always_comb begin
      st_d   = st_q;
      ch_d   = ch_q;
      done_d = done_q;
      case (st_q)
         ST_OFF: begin
            // outputs must be discharged before a new cycle
            if (start_ok_w && all_low_w) begin
               st_d = ST_DLY;
               ch_d = first_ch(active_w);
            end
         end
         ST_DLY: begin
            if (!start_ok_w)
               st_d = ST_OFF;
            else if (phase_tmr.done)
               st_d = ST_UP;
         end
         ST_UP: begin
            if (!start_ok_w)
               st_d = ST_OFF;
            else if (up_fault_w)
               st_d = ST_FAULT;
            else if (up_done_w && track_w) begin
               st_d   = ST_GOOD;
               done_d = active_w;
            end else if (up_done_w) begin
               st_d   = (left_w != CH_NONE) ? ST_DLY : ST_GOOD;
               done_d = done_q | ch_bit_w;
               ch_d   = first_ch(left_w);
            end
         end
         ST_GOOD: begin
            if (!start_ok_w)
               st_d = ST_OFF;
            else if (below_w)
               st_d = ST_FAULT;
            else if (phase_tmr.done)
               st_d = ST_ON;
         end
         ST_ON: begin
            if (!supply_ok_s)
               st_d = ST_OFF;
            else if (below_w)
               st_d = ST_FAULT;
            else if (!enable_s)
               st_d = ST_DOWN;
         end
         ST_DOWN: begin
            if (!supply_ok_s || all_low_w)
               st_d = ST_OFF;
            else if (trk_bad_w)
               st_d = ST_FAULT;
         end
         ST_FAULT: begin
            // latch-off needs the request to drop first
            if (retry_w ? (phase_tmr.done && all_low_w) : !enable_s)
               st_d = ST_OFF;
         end
         default: st_d = ST_OFF;
      endcase
      if (st_d == ST_OFF || st_d == ST_FAULT)
         done_d = CH_NONE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // timers

   wire enter_w = (st_d != st_q);

   assign phase_tmr.start = enter_w & (st_d == ST_DLY || st_d == ST_GOOD || st_d == ST_FAULT);
   assign phase_tmr.load  = (st_d == ST_DLY) ? seq_time_q :
                            (st_d == ST_GOOD) ? good_time_q : retry_time_q;
   assign phase_tmr.run   = ce_i;
   assign fault_tmr.start = enter_w & (st_d == ST_UP);
   assign fault_tmr.load  = fault_time_q;
   assign fault_tmr.run   = ce_i;

   stc_timer u_phase_tmr (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .tmr       (phase_tmr.tmr)
   );

   stc_timer u_fault_tmr (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .tmr       (fault_tmr.tmr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // output decode

   // completed channels stay enhanced through the delay before the next channel
   wire       run_w       = (st_d == ST_DLY || st_d == ST_UP || st_d == ST_GOOD || st_d == ST_ON);
   wire [2:0] up_gates_w  = track_w ? active_w : chan_bit(ch_d);
   wire [2:0] gate_ramp_d = (st_d == ST_UP) ? up_gates_w :
                            (st_d == ST_DOWN) ? active_w : CH_NONE;
   wire [2:0] gate_full_d = run_w ? (done_d & active_w) : CH_NONE;
   wire [2:0] pulldown_d  = (st_d == ST_FAULT || st_d == ST_OFF) ? PD_ALL : CH_NONE;
   wire       ramp_up_d   = (st_d == ST_UP) & track_w;
   wire       ramp_down_d = (st_d == ST_DOWN);
   wire       ramp_hold_d = (ramp_up_d | ramp_down_d) & slow_w;
   wire       pg_d        = mon_w ? (st_d == ST_ON) : pg_q;
   wire       fault_n_d   = mon_w ? (st_d != ST_FAULT) : fault_n_q;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q        <= ST_OFF;
         ch_q        <= 2'h0;
         done_q      <= CH_NONE;
         gate_ramp_q <= CH_NONE;
         gate_full_q <= CH_NONE;
         pulldown_q  <= PD_ALL;
         ramp_up_o   <= 1'b0;
         ramp_down_q <= 1'b0;
         ramp_hold_q <= 1'b0;
         pg_q        <= 1'b0;
         fault_n_q   <= 1'b1;
      end else if (ce_i) begin
         st_q        <= st_d;
         ch_q        <= ch_d;
         done_q      <= done_d;
         gate_ramp_q <= gate_ramp_d;
         gate_full_q <= gate_full_d;
         pulldown_q  <= pulldown_d;
         ramp_up_o   <= ramp_up_d;
         ramp_down_q <= ramp_down_d;
         ramp_hold_q <= ramp_hold_d;
         pg_q        <= pg_d;
         fault_n_q   <= fault_n_d;
      end
   end

   assign gate_ramp_o       = gate_ramp_q;
   assign gate_full_o       = gate_full_q;
   assign pulldown_o        = pulldown_q;
   assign ramp_down_o       = ramp_down_q;
   assign ramp_hold_o       = ramp_hold_q;
   assign power_good_flag_o = pg_q;
   assign fault_n_o         = fault_n_q;

   ////////////////////////////////////////////////////////////////////////////
   // apb registers, zero wait states; the bus stays live while ce_i is low

   logic [31:0] status_w;

   always_comb begin
      status_w                                     = '0;
      status_w[STS_STATE_POS +: 7]                 = st_q;
      status_w[STS_CH_POS +: 2]                    = ch_q;
      status_w[STS_DONE_POS +: 3]                  = done_q;
      status_w[STS_ACTIVE_POS +: 3]                = active_w;
      status_w[STS_PG_POS]                         = pg_q;
      status_w[STS_FAULTN_POS]                     = fault_n_q;
      status_w[STS_TRACK_POS]                      = track_w;
      status_w[STS_RETRY_POS]                      = retry_w;
   end

   wire        setup_w = psel_i & ~penable_i;
   wire        wr_w    = psel_i & penable_i & pwrite_i & pready_o;
   wire        hit_w   = (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_FAULT_TIME) ||
                         (paddr_i == ADDR_RETRY_TIME) || (paddr_i == ADDR_GOOD_TIME) ||
                         (paddr_i == ADDR_SEQ_TIME);
   wire [31:0] rd_w    = (paddr_i == ADDR_STATUS) ? status_w :
                         (paddr_i == ADDR_FAULT_TIME) ? {8'h00, fault_time_q} :
                         (paddr_i == ADDR_RETRY_TIME) ? {8'h00, retry_time_q} :
                         (paddr_i == ADDR_GOOD_TIME) ? {8'h00, good_time_q} :
                         (paddr_i == ADDR_SEQ_TIME) ? {8'h00, seq_time_q} : 32'h0000_0000;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prdata_o     <= 32'h0000_0000;
         pready_o     <= 1'b0;
         pslverr_o    <= 1'b0;
         fault_time_q <= FAULT_CYC_P;
         retry_time_q <= RETRY_CYC_P;
         good_time_q  <= GOOD_CYC_P;
         seq_time_q   <= SEQ_CYC_P;
      end else begin
         pready_o <= 1'b1;
         if (setup_w) begin
            prdata_o  <= rd_w;
            pslverr_o <= ~hit_w;
         end
         if (wr_w && paddr_i == ADDR_FAULT_TIME)
            fault_time_q <= pwdata_i[TW-1:0];
         if (wr_w && paddr_i == ADDR_RETRY_TIME)
            retry_time_q <= pwdata_i[TW-1:0];
         if (wr_w && paddr_i == ADDR_GOOD_TIME)
            good_time_q <= pwdata_i[TW-1:0];
         if (wr_w && paddr_i == ADDR_SEQ_TIME)
            seq_time_q <= pwdata_i[TW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking dc @(posedge clock_i); endclocking
   default disable iff (!reset_n_i || !ce_i);

   chk_pg_after_delay: assert property (
      $rose(pg_q) && $past(mon_w, 2) |-> $past(st_q) == ST_GOOD && $past(phase_tmr.done))
      else $error("power good rose without the good delay");
   chk_fault_period: assert property (
      (st_q == ST_UP && start_ok_w && mon_w && fault_tmr.done) |=> st_q == ST_FAULT && !fault_n_q)
      else $error("fault period expiry did not raise fault");
   chk_track_window: assert property (
      (st_q == ST_UP && start_ok_w && track_w && trk_bad_w) |=> !fault_n_q)
      else $error("tracking error did not raise fault");
   chk_rail_below_in: assert property (
      (st_q == ST_ON && supply_ok_s && below_w) |=> !fault_n_q ##1 pulldown_q == PD_ALL)
      else $error("output below input did not raise fault");
   chk_fault_pulldown: assert property (
      st_q == ST_FAULT |-> pulldown_q == PD_ALL && gate_full_q == CH_NONE)
      else $error("fault without all pulldowns");
   chk_abort_gates: assert property (
      (st_q == ST_UP && start_ok_w && up_fault_w) |=> (gate_ramp_q | gate_full_q) == CH_NONE)
      else $error("gates still driven after abort");
   chk_full_after_up: assert property (
      (gate_full_q & ~done_q) == CH_NONE)
      else $error("full enhancement before power-up done");
   chk_lockout_hold: assert property (
      (st_q == ST_OFF && !supply_ok_s)
      |=> st_q == ST_OFF ##1 (st_q == ST_OFF || $past(supply_ok_s)))
      else $error("left idle below lockout");
   chk_inputs_valid: assert property (
      (st_q == ST_OFF && !(&set_ok_s)) |=> st_q == ST_OFF)
      else $error("left idle with an invalid input");
   chk_ramp_hold: assert property (
      (st_q == ST_UP && st_d == ST_UP && track_w && slow_w) |=> ramp_hold_q && ramp_up_o)
      else $error("ramp not held for a lagging output");
   chk_seq_order: assert property (
      (!track_w && st_q == ST_UP) |-> $onehot(gate_ramp_q) && (gate_ramp_q & done_q) == CH_NONE)
      else $error("sequencing drove more than one channel");
   chk_latch_hold: assert property (
      (st_q == ST_FAULT && !retry_w && enable_s) |=> st_q == ST_FAULT && !fault_n_q)
      else $error("latch-off left fault early");
   chk_orderly_down: assert property (
      (st_q == ST_ON && supply_ok_s && !below_w && !enable_s)
      |=> st_q == ST_DOWN && ramp_down_q && pulldown_q == CH_NONE)
      else $error("orderly shutoff was not a tracked ramp down");
   chk_margin_freeze: assert property (
      !mon_w |=> $stable(pg_q) && $stable(fault_n_q))
      else $error("flags changed during margin");

   cov_power_on:  cover property (st_q == ST_GOOD ##1 st_q == ST_ON);
   cov_fault_up:  cover property (st_q == ST_UP ##1 st_q == ST_FAULT);
   cov_ramp_down: cover property (st_q == ST_DOWN ##1 st_q == ST_OFF);
   cov_seq_next:  cover property (!track_w && st_q == ST_DLY && done_q != CH_NONE);
endmodule
`default_nettype wire

// ### tb/stc_rail_model.sv
// behavioural pass transistors and output rails beside the controller
`timescale 1ns/1ps
`default_nettype none
module stc_rail_model (
   // clock and gate drive
   input  wire logic       clock_i,
   input  wire logic [2:0] gate_i,
   input  wire logic [2:0] pulldown_i,
   input  wire logic       ramp_down_i,
   // faults commanded by the bench
   input  wire logic       stall_i,
   input  wire logic [2:0] below_i,
   input  wire logic [2:0] err_i,
   // comparator results
   output logic      [2:0] good_o,
   output logic      [2:0] low_o,
   output logic      [2:0] below_o,
   output logic      [2:0] slow_o,
   output logic      [2:0] err_o
);
   logic [3:0] lvl_q [3] = '{4'h0, 4'h0, 4'h0};
   // rail falls when discharged, ungated or ramped down, else rises slowly unless stalled
   always_ff @(posedge clock_i) begin
      for (int c = 0; c < 3; c++) begin
         if (pulldown_i[c] || !gate_i[c] || ramp_down_i) begin
            lvl_q[c] <= (lvl_q[c] == 4'h0) ? 4'h0 : lvl_q[c] - 4'h1;
         end else if (!stall_i && lvl_q[c] != 4'hF) begin
            lvl_q[c] <= lvl_q[c] + 4'h1;
         end
      end
   end
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         good_o[c] = lvl_q[c] > 4'hB;
         low_o[c]  = lvl_q[c] == 4'h0;
      end
   end
   // the far side errs only when the bench commands it
   assign slow_o  = stall_i ? gate_i : 3'h0;
   assign below_o = below_i;
   assign err_o   = err_i;
endmodule
`default_nettype wire

// ### tb/stc_ctrl_tb.sv
// self-checking bench of the supply track and sequence controller
`timescale 1ns/1ps
`default_nettype none
module stc_ctrl_tb;
   import stc_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0, prd, rd;
   logic prdy, perr, er, sup = 1'b1, en = 1'b0, mrg_n = 1'b1, trk = 1'b0;
   logic rtr = 1'b0, stall = 1'b0, ce = 1'b1, rup;
   logic [2:0] sok = 3'h7, gnd = 3'h0, blw = 3'h0, terr = 3'h0;
   logic [2:0] og, ol, ob, os, te, gr, gf;
   logic [3:0] flg, pdv;
   logic [7:0] rows [4] = '{8'h07, 8'h47, 8'h23, 8'h55};
   int fail_count = 0, samples_checked = 0, gcnt = 0, hcnt = 0;
   assign pdv[3] = 1'b0;
   initial begin
      forever #12.5 clk = ~clk;
   end
   stc_ctrl #(.GOOD_CYC_P(24'h14), .SEQ_CYC_P(24'h14), .FAULT_CYC_P(24'hC8),
      .RETRY_CYC_P(24'h32)) u_dut (.clock_i(clk), .reset_n_i(rst_n), .ce_i(ce),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
      .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .supply_ok_i(sup),
      .enable_i(en), .margin_n_i(mrg_n), .track_or_sequence_pick_i(trk),
      .latch_or_retry_pick_i(rtr), .set_ok_i(sok), .in_grounded_i(gnd),
      .out_good_i(og), .out_low_i(ol), .out_below_in_i(ob), .out_slow_i(os),
      .track_err_i(te), .gate_ramp_o(gr), .gate_full_o(gf), .pulldown_o(pdv[2:0]),
      .ramp_up_o(rup), .ramp_down_o(flg[3]), .ramp_hold_o(flg[2]),
      .power_good_flag_o(flg[0]), .fault_n_o(flg[1]));
   stc_rail_model u_rail (.clock_i(clk), .gate_i(gr | gf), .pulldown_i(pdv[2:0]),
      .ramp_down_i(flg[3]), .stall_i(stall), .below_i(blw), .err_i(terr),
      .good_o(og), .low_o(ol), .below_o(ob), .slow_o(os), .err_o(te));
   // cycles that every active rail has been good
   always @(posedge clk) gcnt <= ((og & ~gnd) == ~gnd) ? gcnt + 1 : 0;
   // cycles that the ramp has been held; only the stall case raises the hold
   always @(posedge clk) if (flg[2]) hcnt <= hcnt + 1;
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // sample at the falling edge, then return just after a rising edge
   task automatic waitv(ref logic [3:0] s, input logic [3:0] m, input logic [3:0] v);
      int n = 0;
      while ((s & m) !== v && n < 4000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 4000) begin
         fail_count++;
         test_done();
      end
      @(posedge clk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen  <= 1'b0;
      pwr  <= w;
      pa   <= a;
      pwd  <= d;
      @(posedge clk);
      pen <= 1'b1;
      // pready is taken at each rising edge of the access phase
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 50);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
      if (n >= 50) begin
         fail_count++;
         test_done();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   initial begin
      cyc(5);
      chk("pulldown in reset", 32'(pdv), 32'h7);
      rst_n <= 1'b1;
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status state", {25'h0, rd[6:0]}, 32'(ST_OFF));
      apb(1'b1, ADDR_GOOD_TIME, 32'hFF000015);
      apb(1'b0, ADDR_GOOD_TIME, 32'h0);
      chk("good time", rd, 32'h15);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'(er), 32'h1);
      // row: sequencing strap, grounded mask, expected full gates
      foreach (rows[i]) begin
         trk <= rows[i][6]; gnd <= rows[i][5:3]; en <= 1'b1;
         waitv(flg, 4'h1, 4'h1);
         chk("good delay", 32'(gcnt > 21), 32'h1);
         chk("full gates", 32'(gf), 32'(rows[i][2:0]));
         chk("no pulldown", 32'(pdv), 32'h0);
         en <= 1'b0;
         waitv(flg, 4'h8, 4'h8);
         chk("down pulldown", 32'(pdv), 32'h0);
         waitv(pdv, 4'h7, 4'h7);
      end
      gnd <= 3'h0;
      sup <= 1'b0; en <= 1'b1;
      cyc(60);
      chk("lockout", 32'(gr), 32'h0);
      chk("lockout pulldown", 32'(pdv), 32'h7);
      sup <= 1'b1; sok <= 3'h6;
      cyc(60);
      chk("set invalid", 32'(gr), 32'h0);
      chk("set invalid pulldown", 32'(pdv), 32'h7);
      en <= 1'b0; sok <= 3'h7; trk <= 1'b0; terr <= 3'h2;
      cyc(10);
      en <= 1'b1;
      waitv(flg, 4'h2, 4'h0);
      chk("fault pulldown", 32'(pdv), 32'h7);
      chk("fault gates", 32'(gr | gf), 32'h0);
      terr <= 3'h0;
      cyc(80);
      chk("latched fault", 32'(flg[1]), 32'h0);
      en <= 1'b0;
      waitv(flg, 4'h2, 4'h2);
      rtr <= 1'b1; terr <= 3'h4; en <= 1'b1;
      waitv(flg, 4'h2, 4'h0);
      terr <= 3'h0;
      waitv(flg, 4'h3, 4'h3);
      // enable low freezes the controller, the register bus stays live
      ce <= 1'b0;
      en <= 1'b0;
      cyc(10);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("frozen state", {25'h0, rd[6:0]}, 32'(ST_ON));
      chk("frozen flags", 32'(flg), 32'h3);
      ce <= 1'b1;
      en <= 1'b1;
      // reset in mid-run drops everything and restores the times
      rst_n <= 1'b0;
      cyc(2);
      chk("reset flags", 32'(flg), 32'h2);
      chk("reset gates", 32'(gr | gf), 32'h0);
      chk("reset pulldown", 32'(pdv), 32'h7);
      rst_n <= 1'b1;
      apb(1'b0, ADDR_GOOD_TIME, 32'h0);
      chk("reset good time", rd, 32'h14);
      waitv(flg, 4'h3, 4'h3);
      mrg_n <= 1'b0; blw <= 3'h1;
      cyc(20);
      chk("margin freeze", 32'(flg[1:0]), 32'h3);
      mrg_n <= 1'b1;
      waitv(flg, 4'h2, 4'h0);
      chk("below pulldown", 32'(pdv), 32'h7);
      blw <= 3'h0; en <= 1'b0;
      waitv(flg, 4'h2, 4'h2);
      stall <= 1'b1; en <= 1'b1;
      waitv(flg, 4'h4, 4'h4);
      chk("ramp up", 32'(rup), 32'h1);
      waitv(flg, 4'h2, 4'h0);
      chk("slow fault long", 32'(gcnt == 0), 32'h1);
      chk("fault period", 32'(hcnt > 190 && hcnt < 202), 32'h1);
      stall <= 1'b0; en <= 1'b0;
      waitv(flg, 4'h2, 4'h2);
      test_done();
   end
endmodule
`default_nettype wire
